// file: cfg_host_model.sv
// Purpose: external host driving the configuration link pins
// Assumes: link clock 48 ns period, low between images
// Notes: data changes on the falling link edge, held 24 ns each side of the rise
`timescale 1ns/1ps
module cfg_host_model (
  // link pins
  output logic       config_clock_in,
  output logic [7:0] data_in
);
  import cfg_loader_pkg::*;

  initial
  begin
    config_clock_in = 1'b0;
    data_in         = 8'h5a;
  end

  // ------------------------------------------------------------------
  // one link clock period with a value set up before the rise
  // ------------------------------------------------------------------
  task automatic edge_out(input logic [7:0] v);
    data_in = v;
    #24 config_clock_in = 1'b1;
    #24 config_clock_in = 1'b0;
  endtask : edge_out

  // ------------------------------------------------------------------
  // whole image; clock stands still afterwards, data no longer valid
  // ------------------------------------------------------------------
  task automatic send_stream(input logic [1:0] mode, input logic enc, input logic [7:0] s[$]);
    int edges;
    for (int i = 0; i < s.size(); i++)
    begin
      edges = (mode == MODE_PARALLEL && enc && i > 0) ? 4 : 1;
      if (mode == MODE_SERIAL || mode == MODE_ACTIVE)
        for (int b = 7; b >= 0; b--)
          edge_out({~data_in[7:1], s[i][b]});
      else
        for (int e = 0; e < edges; e++)
          edge_out(s[i]);
    end
    data_in = ~data_in;
  endtask : send_stream
endmodule : cfg_host_model

// file: cfg_loader.sv
// Purpose: configuration image loader with decrypt, expand and frame crc check
// Assumes: link pins asynchronous to mclk; link clock well below mclk/4
// Notes: cipher stage is a keyed byte stream stand-in for the real core
`timescale 1ns/1ps
module cfg_loader #(
  parameter int FRAME_BYTES = 16,
  parameter int NUM_FRAMES  = 64
) (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  // link pins
  input  wire logic                          config_clock_in,
  input  wire logic [7:0]                    data_in,
  input  wire logic                          load_enable,
  input  wire logic [1:0]                    load_mode,
  // key status pins
  input  wire logic                          key_present,
  input  wire logic                          tamper_bit,
  input  wire logic [31:0]                   key_word,
  // config cell writes
  output logic                               cell_wr_valid,
  output logic [$clog2(NUM_FRAMES)-1:0]      cell_wr_frame,
  output logic [$clog2(FRAME_BYTES)-1:0]     cell_wr_byte,
  output logic [7:0]                         cell_wr_data,
  // status
  output logic                               load_done,
  output logic                               load_fail,
  output logic [1:0]                         fail_cause,
  // check-bit readback
  input  wire logic [$clog2(NUM_FRAMES)-1:0] check_rd_addr,
  output logic [cfg_loader_pkg::CHECK_W-1:0] check_rd_data
);
  import cfg_loader_pkg::*;

  localparam int FW = $clog2(NUM_FRAMES);
  localparam int BW = $clog2(FRAME_BYTES);
  localparam int SW = 14;
  localparam logic [BW-1:0] LAST_BYTE  = BW'(FRAME_BYTES - 1);
  localparam logic [FW-1:0] LAST_FRAME = FW'(NUM_FRAMES - 1);

  // refuse sizes the counters cannot serve
  if (FRAME_BYTES < 2 || NUM_FRAMES < 2)
  begin : g_bad_size
    $error("cfg_loader: FRAME_BYTES and NUM_FRAMES must be at least 2");
  end

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      r = (r[15] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1); // [RULE_15]
    end
    return r;
  endfunction : crc16_byte

  function automatic logic [7:0] decrypt_byte(input logic [7:0] b, input logic [31:0] k,
                                              input logic [1:0] idx);
    return b ^ k[8*idx +: 8];
  endfunction : decrypt_byte

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic          clk_prev;
    load_state_t   st;
    logic          enc;
    logic          cmp;
    logic [1:0]    mode;
    logic [1:0]    ecnt;
    logic [2:0]    bcnt;
    logic [7:0]    sh;
    logic [1:0]    kidx;
    logic          esc;
    logic [3:0]    run;
    logic [BW-1:0] bidx;
    logic [FW-1:0] fidx;
    logic [15:0]   crc;
    logic [7:0]    crc_hi;
    logic          cw_v;
    logic [FW-1:0] cw_f;
    logic [BW-1:0] cw_b;
    logic [7:0]    cw_d;
    logic          sw_en;
    logic [FW-1:0] sw_a;
    logic [15:0]   sw_d;
    logic [1:0]    cause;
  } loader_state_t;

  loader_state_t q_r;
  loader_state_t q_nxt;

  logic          clk_s;
  logic [7:0]    dat_s;
  logic          en_s;
  logic          key_s;
  logic          tmp_s;
  logic [1:0]    mode_s;
  logic          rise;
  logic          byte_v;
  logic [7:0]    byte_b;
  logic [7:0]    dec_b;
  logic          emit_v;
  logic [7:0]    emit_b;
  logic          match;

  assign {en_s, key_s, tmp_s, mode_s, clk_s, dat_s} = q_r.s2;
  assign rise  = clk_s && !q_r.clk_prev;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    q_nxt       = q_r;
    q_nxt.s1    = {load_enable, key_present, tamper_bit, load_mode, config_clock_in, data_in};
    q_nxt.s2    = q_r.s1;
    q_nxt.clk_prev = clk_s;
    q_nxt.cw_v  = 1'b0;
    q_nxt.sw_en = 1'b0;
    byte_v      = 1'b0;
    byte_b      = dat_s;
    emit_v      = 1'b0;
    emit_b      = 8'h00;

    // byte assembly from link edges
    if (rise && (q_r.st inside {ST_HDR, ST_DATA, ST_CRC_HI, ST_CRC_LO}))
    begin
      if (q_r.mode == MODE_PARALLEL || q_r.mode == MODE_JTAG)
      begin
        if (q_r.enc && q_r.st != ST_HDR)
        begin
          q_nxt.ecnt = q_r.ecnt + 2'h1;
          byte_v     = (q_r.ecnt == ENC_WORD_LAST); // [RULE_01]
        end
        else
        begin
          byte_v = 1'b1; // [RULE_02]
        end
      end
      else
      begin
        q_nxt.sh   = {q_r.sh[6:0], dat_s[0]};
        q_nxt.bcnt = q_r.bcnt + 3'h1;
        byte_v     = (q_r.bcnt == SER_BIT_LAST); // [RULE_02]
        byte_b     = {q_r.sh[6:0], dat_s[0]};
      end
    end

    // decrypt, then expand zero runs
    dec_b = q_r.enc ? decrypt_byte(byte_b, key_word, q_r.kidx) : byte_b; // [RULE_04] [RULE_05]
    if (q_r.run != 4'h0)
    begin
      q_nxt.run = q_r.run - 4'h1;
      emit_v    = 1'b1;
    end
    else if (byte_v && q_r.st != ST_HDR)
    begin
      q_nxt.kidx = q_r.kidx + 2'h1;
      if (q_r.cmp && q_r.esc)
      begin
        q_nxt.esc = 1'b0;
        q_nxt.run = {1'b0, dec_b[2:0]} + 4'h1; // [RULE_04]
      end
      else if (q_r.cmp && dec_b == RUN_ESCAPE)
      begin
        q_nxt.esc = 1'b1;
      end
      else
      begin
        emit_v = 1'b1;
        emit_b = dec_b;
      end
    end
    match = ({q_r.crc_hi, emit_b} == q_r.crc); // [RULE_08]

    case (q_r.st)
      ST_IDLE:
      begin
        if (en_s)
        begin
          q_nxt.st   = ST_HDR;
          q_nxt.mode = mode_s;
          q_nxt.ecnt = 2'h0;
          q_nxt.bcnt = 3'h0;
          q_nxt.kidx = 2'h0;
          q_nxt.esc  = 1'b0;
          q_nxt.run  = 4'h0;
          q_nxt.bidx = '0;
          q_nxt.fidx = '0;
          q_nxt.crc  = CRC_INIT;
          q_nxt.cause = FAIL_NONE;
        end
      end
      ST_HDR:
      begin
        if (byte_v)
        begin
          q_nxt.enc = byte_b[HDR_ENC_BIT]; // [RULE_17]
          q_nxt.cmp = byte_b[HDR_CMP_BIT];
          q_nxt.st  = ST_DATA;
          if (byte_b[HDR_ENC_BIT] && q_r.mode == MODE_JTAG)
          begin
            q_nxt.st    = ST_FAIL; // [RULE_03]
            q_nxt.cause = FAIL_JTAG;
          end
          else if ((byte_b[HDR_ENC_BIT] && !key_s) || (!byte_b[HDR_ENC_BIT] && tmp_s))
          begin
            q_nxt.st    = ST_FAIL; // [RULE_12] [RULE_13]
            q_nxt.cause = FAIL_KEY;
          end
          // key present and tamper clear falls through for both kinds, except encrypted images over jtag [RULE_14]
        end
      end
      ST_DATA:
      begin
        if (emit_v)
        begin
          q_nxt.crc  = crc16_byte(q_r.crc, emit_b); // [RULE_06] [RULE_10]
          q_nxt.cw_v = 1'b1;
          q_nxt.cw_f = q_r.fidx;
          q_nxt.cw_b = q_r.bidx;
          q_nxt.cw_d = emit_b;
          q_nxt.bidx = q_r.bidx + BW'(1);
          if (q_r.bidx == LAST_BYTE)
          begin
            q_nxt.bidx = '0;
            q_nxt.st   = ST_CRC_HI; // [RULE_07]
          end
        end
      end
      ST_CRC_HI:
      begin
        if (emit_v)
        begin
          q_nxt.crc_hi = emit_b;
          q_nxt.st     = ST_CRC_LO;
        end
      end
      ST_CRC_LO:
      begin
        if (emit_v)
        begin
          if (match) // [RULE_08]
          begin
            q_nxt.sw_en = 1'b1; // [RULE_10] [RULE_11]
            q_nxt.sw_a  = q_r.fidx;
            q_nxt.sw_d  = q_r.crc;
            q_nxt.crc   = CRC_INIT;
            q_nxt.fidx  = q_r.fidx + FW'(1);
            q_nxt.st    = (q_r.fidx == LAST_FRAME) ? ST_DONE : ST_DATA; // [RULE_09]
          end
          else
          begin
            q_nxt.st    = ST_FAIL; // [RULE_09] [RULE_16]
            q_nxt.cause = FAIL_CRC;
          end
        end
      end
      ST_DONE,
      ST_FAIL:
      begin
        if (!en_s)
          q_nxt.st = ST_IDLE;
      end
      default:
      begin
        q_nxt.st = ST_IDLE;
      end
    endcase

    if (!en_s && q_r.st != ST_IDLE)
      q_nxt.st = ST_IDLE;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      q_r <= '{st: ST_IDLE, mode: MODE_PARALLEL, cause: FAIL_NONE, crc: CRC_INIT, default: '0};
    else
      q_r <= q_nxt;
  end

  // ------------------------------------------------------------------
  // check-bit store and outputs
  // ------------------------------------------------------------------
  check_store_if #(.AW(FW), .DW(CHECK_W)) st_if ();

  assign st_if.wr_en   = q_r.sw_en;
  assign st_if.wr_addr = q_r.sw_a;
  assign st_if.wr_data = q_r.sw_d;
  assign st_if.rd_addr = check_rd_addr;
  assign check_rd_data = st_if.rd_data;

  check_store #(.DEPTH(NUM_FRAMES), .AW(FW), .DW(CHECK_W)) u_store (
    .mclk  (mclk),
    .rst_n (rst_n),
    .port  (st_if.store)
  );

  assign cell_wr_valid = q_r.cw_v;
  assign cell_wr_frame = q_r.cw_f;
  assign cell_wr_byte  = q_r.cw_b;
  assign cell_wr_data  = q_r.cw_d;
  assign load_done     = (q_r.st == ST_DONE);
  assign load_fail     = (q_r.st == ST_FAIL);
  assign fail_cause    = q_r.cause;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_enc_word_rate: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_01]
    (rise && q_r.enc && q_r.mode == MODE_PARALLEL && q_r.run == 4'h0 && en_s
     && (q_r.st inside {ST_DATA, ST_CRC_HI, ST_CRC_LO}) && q_r.ecnt != ENC_WORD_LAST)
      |=> (q_r.kidx == $past(q_r.kidx) && !cell_wr_valid))
    else $error("encrypted parallel word taken off the fourth edge");

  a_jtag_refuse: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_03]
    (q_r.st == ST_HDR && byte_v && byte_b[HDR_ENC_BIT] && q_r.mode == MODE_JTAG && en_s)
      |=> (load_fail && fail_cause == FAIL_JTAG))
    else $error("encrypted image accepted over jtag");

  a_tamper_reject: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_12]
    (q_r.st == ST_HDR && byte_v && !byte_b[HDR_ENC_BIT] && tmp_s && en_s)
      |=> (load_fail && fail_cause == FAIL_KEY))
    else $error("plain image accepted with tamper bit set");

  a_nokey_reject: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_13]
    (q_r.st == ST_HDR && byte_v && byte_b[HDR_ENC_BIT] && !key_s && en_s
     && q_r.mode != MODE_JTAG) |=> (load_fail && fail_cause == FAIL_KEY))
    else $error("encrypted image accepted without key");

  a_both_accepted: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_14]
    (q_r.st == ST_HDR && byte_v && key_s && !tmp_s && en_s && q_r.mode != MODE_JTAG)
      |=> (q_r.st == ST_DATA))
    else $error("image refused although key present and tamper clear");

  a_check_stored: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_10]
    (q_r.st == ST_CRC_LO && emit_v && match && en_s)
      |=> (st_if.wr_en && st_if.wr_data == $past(q_r.crc) && st_if.wr_addr == $past(q_r.fidx)))
    else $error("frame check bits not stored");

  a_mismatch_stop: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_08]
    (q_r.st == ST_CRC_LO && emit_v && !match && en_s)
      |=> (load_fail && fail_cause == FAIL_CRC && !st_if.wr_en))
    else $error("crc mismatch did not stop loading");

  a_fail_quiet: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_16]
    (load_fail && en_s) |=> (!cell_wr_valid && !load_done && (load_fail || !$past(en_s))))
    else $error("activity after configuration failure");

  a_done_at_end: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_09]
    ($rose(load_done)) |-> ($past(q_r.fidx) == LAST_FRAME && $past(q_r.st) == ST_CRC_LO))
    else $error("load done before the last frame");
endmodule : cfg_loader

// file: cfg_loader_pkg.sv
// Purpose: constants and types shared by the configuration loader files
// Assumes: byte-wide image stream, header byte first, then frames
// Notes: image = header, then per frame FRAME_BYTES data bytes + crc hi + crc lo
//
// Operation
// RULE_01 - host clocks encrypted parallel images at four edges per data word
// RULE_02 - decryption adds no cycles outside encrypted parallel loading
// RULE_03 - decryption offered in parallel and serial loading, refused over jtag
// RULE_04 - each portion is decrypted first, then decompressed, then written
// RULE_05 - decryption and decompression work together, neither disables the other
// RULE_06 - crc check always runs during load, same polynomial as background check
// RULE_07 - stream carries a crc value after every data frame
// RULE_08 - crc computed per frame and compared with the frame's carried crc
// RULE_09 - load runs frame by frame, stops at first crc fail or at image end
// RULE_10 - parallel engine makes 16 check bits per frame and stores them
// RULE_11 - check-bit store is 16 bits wide with one entry per frame
// RULE_12 - tamper protection set rejects every unencrypted image
// RULE_13 - no key programmed accepts only unencrypted images
// RULE_14 - key present without tamper bit accepts both image kinds
// RULE_15 - frame crc uses the 16-bit crc-ansi generator polynomial
// RULE_16 - crc mismatch stops loading and reports failure instead of user mode
// RULE_17 - header bit selects decryption per image
package cfg_loader_pkg;

  // ------------------------------------------------------------------
  // load modes
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_PARALLEL = 2'h0;
  localparam logic [1:0] MODE_SERIAL   = 2'h1;
  localparam logic [1:0] MODE_ACTIVE   = 2'h2;
  localparam logic [1:0] MODE_JTAG     = 2'h3;

  // ------------------------------------------------------------------
  // header, crc and timing constants
  // ------------------------------------------------------------------
  localparam int         HDR_ENC_BIT   = 0;
  localparam int         HDR_CMP_BIT   = 1;
  localparam logic [7:0] RUN_ESCAPE    = 8'h00;
  localparam logic [15:0] CRC_POLY     = 16'h8005;
  localparam logic [15:0] CRC_INIT     = 16'h0000;
  localparam int          CHECK_W      = 16;
  localparam logic [1:0]  ENC_WORD_LAST = 2'h3;
  localparam logic [2:0]  SER_BIT_LAST  = 3'h7;
  localparam logic [1:0]  FAIL_NONE    = 2'h0;
  localparam logic [1:0]  FAIL_CRC     = 2'h1;
  localparam logic [1:0]  FAIL_KEY     = 2'h2;
  localparam logic [1:0]  FAIL_JTAG    = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HDR,
    ST_DATA,
    ST_CRC_HI,
    ST_CRC_LO,
    ST_DONE,
    ST_FAIL
  } load_state_t;

endpackage : cfg_loader_pkg

// file: check_store.sv
// Purpose: per-frame check-bit store
// Assumes: DEPTH equals the number of frames
// Notes: registered read, one cycle latency
`timescale 1ns/1ps
module check_store #(
  parameter int DEPTH = 64,
  parameter int AW    = 6,
  parameter int DW    = 16
) (
  // clock and reset
  input  wire logic    mclk,
  input  wire logic    rst_n,
  // ports
  check_store_if.store port
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rd_r;

  // refuse a depth the address cannot reach
  if (DEPTH < 2 || DEPTH > (1 << AW))
  begin : g_bad_depth
    $error("check_store: DEPTH does not fit AW");
  end

  always_ff @(posedge mclk)
  begin
    if (port.wr_en)
      mem[port.wr_addr] <= port.wr_data;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rd_r <= '0;
    else
      rd_r <= mem[port.rd_addr];
  end

  assign port.rd_data = rd_r;
endmodule : check_store

// file: check_store_if.sv
// Purpose: write and read port group of the check-bit store
// Assumes: one clock shared by loader and store
// Notes: read data registered in the store
`timescale 1ns/1ps
interface check_store_if #(parameter int AW = 6, parameter int DW = 16);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport loader (output wr_en, output wr_addr, output wr_data, output rd_addr,
                  input rd_data);
  modport store  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                  output rd_data);
endinterface : check_store_if

// file: tb_secure_config_frame_crc_loader.sv
// Purpose: self-checking bench of the configuration loader
// Assumes: two frames of two bytes, host model on the link pins
// Notes: images built here: header, data, crc hi/lo, optional expand and cipher
`timescale 1ns/1ps
module tb_secure_config_frame_crc_loader;
  import cfg_loader_pkg::*;
  localparam int FB = 2;
  localparam int NF = 2;
  localparam int FW = $clog2(NF);
  localparam int BW = $clog2(FB);

  logic                 mclk;
  logic                 rst_n;
  logic                 config_clock_in;
  logic [7:0]           data_in;
  logic                 load_enable;
  logic [1:0]           load_mode;
  logic                 key_present;
  logic                 tamper_bit;
  logic [31:0]          key_word;
  logic                 cell_wr_valid;
  logic [FW-1:0]        cell_wr_frame;
  logic [BW-1:0]        cell_wr_byte;
  logic [7:0]           cell_wr_data;
  logic                 load_done;
  logic                 load_fail;
  logic [1:0]           fail_cause;
  logic [FW-1:0]        check_rd_addr;
  logic [CHECK_W-1:0]   check_rd_data;
  logic [15:0]          got_q[$];
  logic [15:0]          exp_q[$];
  logic [23:0]          cases[16];
  int                   num_errors;
  int                   num_checks;

  cfg_loader #(.FRAME_BYTES(FB), .NUM_FRAMES(NF)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .config_clock_in(config_clock_in), .data_in(data_in),
    .load_enable(load_enable), .load_mode(load_mode), .key_present(key_present),
    .tamper_bit(tamper_bit), .key_word(key_word), .cell_wr_valid(cell_wr_valid),
    .cell_wr_frame(cell_wr_frame), .cell_wr_byte(cell_wr_byte), .cell_wr_data(cell_wr_data),
    .load_done(load_done), .load_fail(load_fail), .fail_cause(fail_cause),
    .check_rd_addr(check_rd_addr), .check_rd_data(check_rd_data));

  cfg_host_model i_host (.config_clock_in(config_clock_in), .data_in(data_in));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk)
    if (cell_wr_valid === 1'b1)
      got_q.push_back({cell_wr_frame, cell_wr_byte, cell_wr_data});

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = (c[15] ^ b[i]) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
    return c;
  endfunction : crc16

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // ------------------------------------------------------------------
  // one image load; bad = frame with corrupted crc (>= NF for none)
  // ------------------------------------------------------------------
  task automatic run_load(input int id, input logic [1:0] mode, input logic [1:0] hdr,
                          input logic key, input logic tamp, input int bad,
                          input logic [1:0] cause);
    logic [7:0]  raw[$];
    logic [7:0]  s[$];
    logic [7:0]  b;
    logic [15:0] crc;
    logic [15:0] crcs[NF];
    int          keep;
    raw = {};
    exp_q = {};
    for (int f = 0; f < NF; f++)
    begin
      crc = CRC_INIT;
      for (int k = 0; k < FB; k++)
      begin
        b = (hdr[1] && f == 0) ? 8'h00 : 8'($urandom);
        raw.push_back(b);
        crc = crc16(crc, b);
        exp_q.push_back(16'({FW'(f), BW'(k), b}));
      end
      crcs[f] = crc;
      if (f == bad)
        crc = ~crc;
      raw.push_back(crc[15:8]);
      raw.push_back(crc[7:0]);
    end
    s = {{6'h00, hdr}};
    for (int i = 0; i < raw.size(); i++)
      if (hdr[1] && raw[i] == 8'h00)
      begin
        s.push_back(RUN_ESCAPE);
        if (i % (FB + 2) == 0 && raw[i+1] == 8'h00)
        begin
          s.push_back(8'h01);
          i++;
        end
        else
          s.push_back(8'h00);
      end
      else
        s.push_back(raw[i]);
    if (hdr[0])
      for (int j = 1; j < s.size(); j++)
        s[j] = s[j] ^ key_word[8*((j-1)%4) +: 8];
    keep = (cause == FAIL_CRC) ? (bad + 1) * FB : ((cause == FAIL_NONE) ? NF * FB : 0);
    while (exp_q.size() > keep)
      void'(exp_q.pop_back());
    got_q = {};
    @(posedge mclk);
    #1;
    load_mode = mode;
    key_present = key;
    tamper_bit = tamp;
    repeat (4) @(posedge mclk);
    #1 load_enable = 1'b1;
    repeat (8) @(posedge mclk);
    i_host.send_stream(mode, hdr[0], s);
    repeat (20) @(posedge mclk);
    #1;
    chk(load_done, cause == FAIL_NONE);
    chk(load_fail, cause != FAIL_NONE);
    chk(fail_cause, cause);
    chk(got_q.size(), exp_q.size());
    foreach (exp_q[i])
      if (i < got_q.size())
        chk(got_q[i], exp_q[i]);
    if (cause == FAIL_NONE)
      for (int f = 0; f < NF; f++)
      begin
        check_rd_addr = FW'(f);
        @(posedge mclk);
        #1 chk(check_rd_data, crcs[f]);
      end
    load_enable = 1'b0;
    repeat (6) @(posedge mclk);
    #1 chk({load_done, load_fail}, 2'b00);
    $display("test %0d finished", id);
  endtask : run_load

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial
  begin
    int m;
    int h;
    int bd;
    rst_n = 1'b0;
    load_enable = 1'b0;
    load_mode = MODE_PARALLEL;
    key_present = 1'b0;
    tamper_bit = 1'b0;
    key_word = 32'h0000_0000;
    check_rd_addr = '0;
    num_errors = 0;
    num_checks = 0;
    void'($urandom(73739));
    // fields: mode, header, key, tamper, bad frame, cause
    cases = '{24'h000030, 24'h100030, 24'h201030, 24'h300030, 24'h011030, 24'h111030,
              24'h211030, 24'h031030, 24'h131030, 24'h220030, 24'h311033, 24'h010032,
              24'h101132, 24'h111130, 24'h001001, 24'h131011};
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    foreach (cases[i])
    begin
      key_word = $urandom;
      run_load(i, cases[i][21:20], cases[i][17:16], cases[i][12], cases[i][8],
               int'(cases[i][7:4]), cases[i][1:0]);
    end
    for (int i = 0; i < 6; i++)
    begin
      key_word = $urandom;
      m = $urandom % 3;
      h = $urandom % 4;
      bd = $urandom % 4;
      run_load(16 + i, 2'(m), 2'(h), 1'b1, 1'b0, bd,
               (bd < NF) ? FAIL_CRC : FAIL_NONE);
    end
    results();
  end

  initial
  begin
    #250us;
    num_errors++;
    results();
  end
endmodule : tb_secure_config_frame_crc_loader
